//--- mmd_decoder.sv
// Memory map decoder: data and program steering, paging, overlay, protection, vectors
//
// Behaviour
// - Data space is 64K x16; on-chip RAM range and registers 001Dh/001Eh served inside, rest external.
// - Mapped on-chip program memory served inside; other program addresses go external unless an external data access holds the bus that cycle.
// - Program space extends by paging to 8192K words over 23 address lines.
// - Extended program memory is 128 pages of 64K words.
// - Page register at data 001Eh, read/write, cleared by hardware reset.
// - 64K-word maskable ROM decoded in program space.
// - ROM-enable pin low at reset starts execution from ROM at FF80h.
// - Five 8K blocks, each two reads or read plus write per cycle.
// - RAM at data 0080h-9FFFh; also in program space when overlay set.
// - Overlay puts on-chip RAM in lower 32K of every page; else external.
// - ROM protection blocks externally fetched code from reading on-chip ROM.
// - RAM protection: host writes free, host reads only 2000h-3FFFh.
// - Reset, interrupt or trap loads the PC with its vector address.
// - Each vector slot reserves four words.
// - Writing vector pointer relocates later vectors to that 128-word page.
// - Hardware reset sets pointer to ones; reset vector always FF80h.
// - Mode register: pointer 15:7 reset 1FF, bit 6 pin, 5:0 RW zero.
// - Data page zero never decoded into program space.
// - ROM-enable bit caught at reset only; software may change; one disables ROM.
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.svh"
module mmd_decoder #(
    parameter int NUM_BLOCKS = 5,
    parameter int BLOCK_AW = 13,
    parameter bit ROM_PROTECT = 1'b0,
    parameter bit RAM_PROTECT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Strap pin
    input wire logic rom_enable_select_pin,
    // Data space access from the CPU
    input wire logic d_req,
    input wire logic d_we,
    input wire logic [15:0] d_addr,
    input wire logic [15:0] d_wdata,
    // Program space access from the CPU
    input wire logic p_req,
    input wire logic [15:0] p_addr,
    input wire logic fetch_from_ext,
    // Host port access
    input wire logic hp_req,
    input wire logic hp_we,
    input wire logic [15:0] hp_addr,
    input wire logic [15:0] hp_wdata,
    // Vector requests
    input wire logic vec_take,
    input wire logic [4:0] vec_num,
    // ROM contents supplied by the array outside
    output logic rom_req,
    output logic [16:0] rom_addr,
    input wire logic [15:0] rom_rdata,
    // Answers
    output logic [15:0] d_rdata,
    output logic [15:0] p_rdata,
    output logic [15:0] hp_rdata,
    output logic hp_denied,
    output logic p_rom_denied,
    output logic [2:0] d_target,
    output logic [2:0] p_target,
    // External bus
    output logic ext_d_req,
    output logic ext_p_req,
    output logic ext_we,
    output logic [22:0] ext_addr,
    output logic [15:0] ext_wdata,
    // Vector to the program counter
    output logic pc_load,
    output logic [15:0] pc_vector,
    // Mode bits to the rest of the core
    output logic [15:0] page_sel,
    output logic [15:0] mode_ctrl
);
    logic [15:0] program_page_select;
    logic [8:0] vector_pointer;
    logic rom_enable_select;
    logic [5:0] mode_low;
    logic strap_pend;
    logic [15:0] next_program_page_select;
    logic [8:0] next_vector_pointer;
    logic next_rom_enable_select;
    logic [5:0] next_mode_low;
    logic next_strap_pend;

    logic ram_overlay;
    logic d_in_ram, p_in_ram, p_in_rom, hp_in_ram, hp_rd_ok;
    logic [15:0] ram_a_addr, ram_b_addr;
    logic ram_a_en, ram_b_en, ram_b_we;
    logic [15:0] ram_b_wdata;
    logic [15:0] blk_a_rdata [NUM_BLOCKS];
    logic [15:0] blk_b_rdata [NUM_BLOCKS];
    logic [2:0] a_sel, b_sel;
    logic [2:0] a_sel_q, b_sel_q, next_a_sel_q, next_b_sel_q;
    logic d_reg_rd, d_reg_q, next_d_reg_q;
    logic p_rom_q, next_p_rom_q;
    logic hp_rd_q, next_hp_rd_q, hp_ok_q, next_hp_ok_q;
    logic [15:0] reg_rdata_q, next_reg_rdata_q;
    logic [15:0] next_d_rdata, next_p_rdata, next_hp_rdata;
    logic next_hp_denied, next_p_rom_denied, next_rom_req;
    logic [16:0] next_rom_addr;
    logic [2:0] next_d_target, next_p_target;
    logic next_ext_d_req, next_ext_p_req, next_ext_we;
    logic [22:0] next_ext_addr;
    logic [15:0] next_ext_wdata;
    logic vec_valid;
    logic [15:0] vec_addr;
    logic [15:0] mode_word;

    assign ram_overlay = mode_low[`MMD_RAM_OVERLAY_BIT];
    assign mode_word = {vector_pointer, rom_enable_select, mode_low};

    // Control registers
    always_comb
    begin
        next_program_page_select = program_page_select;
        next_vector_pointer = vector_pointer;
        next_rom_enable_select = rom_enable_select;
        next_mode_low = mode_low;
        next_strap_pend = 1'b0;
        if (strap_pend)
        begin
            next_rom_enable_select = rom_enable_select_pin;
        end
        if (d_req && d_we && d_addr == `MMD_PAGE_SEL_ADDR)
        begin
            next_program_page_select = {9'h000, d_wdata[6:0]};
        end
        else if (d_req && d_we && d_addr == `MMD_MODE_CTRL_ADDR)
        begin
            next_vector_pointer = d_wdata[`MMD_VPTR_MSB:`MMD_VPTR_LSB];
            next_rom_enable_select = d_wdata[`MMD_ROM_EN_BIT];
            next_mode_low = d_wdata[5:0];
        end
    end

    // Strap is caught on the first clock after reset release, never under reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            program_page_select <= `MMD_PAGE_SEL_RESET;
            vector_pointer <= `MMD_VPTR_RESET;
            rom_enable_select <= 1'b1;
            mode_low <= `MMD_MODE_LOW_RESET;
            strap_pend <= 1'b1;
        end
        else
        begin
            program_page_select <= next_program_page_select;
            vector_pointer <= next_vector_pointer;
            rom_enable_select <= next_rom_enable_select;
            mode_low <= next_mode_low;
            strap_pend <= next_strap_pend;
        end
    end

    // Address decode
    always_comb
    begin
        d_in_ram = d_addr >= `MMD_RAM_LO && d_addr <= `MMD_RAM_HI;
        // Overlay only reaches the lower 32K of each page, page zero of data excluded
        p_in_ram = ram_overlay && p_addr >= `MMD_RAM_LO && p_addr <= `MMD_OVL_HI;
        // ROM lives in the upper half of page 0 and 1; pages above are external
        p_in_rom = !rom_enable_select && p_addr >= `MMD_ROM_LO
            && program_page_select[6:1] == 6'h00;
        hp_in_ram = hp_addr >= `MMD_RAM_LO && hp_addr <= `MMD_RAM_HI;
        hp_rd_ok = !RAM_PROTECT || (hp_addr >= `MMD_HP_RD_LO && hp_addr <= `MMD_HP_RD_HI);
        d_reg_rd = d_req && !d_we && (d_addr == `MMD_PAGE_SEL_ADDR || d_addr == `MMD_MODE_CTRL_ADDR);
    end

    // RAM port steering: port a serves program, port b data; host uses b when data does not access RAM
    always_comb
    begin
        ram_a_en = p_req && p_in_ram;
        ram_a_addr = p_addr;
        ram_b_en = 1'b0;
        ram_b_we = 1'b0;
        ram_b_addr = d_addr;
        ram_b_wdata = d_wdata;
        if (d_req && d_in_ram)
        begin
            ram_b_en = 1'b1;
            ram_b_we = d_we;
        end
        else if (hp_req && hp_in_ram && (hp_we || hp_rd_ok))
        begin
            ram_b_en = 1'b1;
            ram_b_we = hp_we;
            ram_b_addr = hp_addr;
            ram_b_wdata = hp_wdata;
        end
        a_sel = 3'(ram_a_addr[15:13]);
        b_sel = 3'(ram_b_addr[15:13]);
    end

    // Block address is the word address within its 8K block
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BLOCKS; gi++)
        begin : g_blk
            mmd_ram_block #(.AW(BLOCK_AW), .DW(16)) u_blk (
                .clk(clk),
                .a_en(ram_a_en && a_sel == 3'(gi)),
                .a_addr(ram_a_addr[BLOCK_AW-1:0]),
                .a_rdata(blk_a_rdata[gi]),
                .b_en(ram_b_en && b_sel == 3'(gi)),
                .b_we(ram_b_we),
                .b_addr(ram_b_addr[BLOCK_AW-1:0]),
                .b_wdata(ram_b_wdata),
                .b_rdata(blk_b_rdata[gi])
            );
        end
    endgenerate

    mmd_vector_gen u_vec (
        .clk(clk),
        .rst_b(rst_b),
        .take(vec_take || strap_pend),
        .is_hw_reset(strap_pend),
        .vec_num(vec_num),
        .vptr(vector_pointer),
        .vec_valid(vec_valid),
        .vec_addr(vec_addr)
    );

    // Request side outputs, registered
    always_comb
    begin
        next_d_target = mmd_pkg::MMD_TGT_NONE;
        next_p_target = mmd_pkg::MMD_TGT_NONE;
        next_ext_d_req = 1'b0;
        next_ext_p_req = 1'b0;
        next_ext_we = 1'b0;
        next_ext_addr = ext_addr;
        next_ext_wdata = ext_wdata;
        next_rom_req = 1'b0;
        next_rom_addr = rom_addr;
        next_p_rom_denied = 1'b0;
        next_hp_denied = hp_req && !hp_we && !hp_rd_ok;
        next_a_sel_q = a_sel;
        next_b_sel_q = b_sel;
        next_d_reg_q = d_reg_rd;
        next_p_rom_q = 1'b0;
        next_hp_rd_q = hp_req && !hp_we && hp_in_ram && !(d_req && d_in_ram);
        next_hp_ok_q = hp_rd_ok;
        next_reg_rdata_q = (d_addr == `MMD_PAGE_SEL_ADDR) ? program_page_select : mode_word;
        if (d_req)
        begin
            if (d_in_ram || d_addr == `MMD_PAGE_SEL_ADDR || d_addr == `MMD_MODE_CTRL_ADDR)
            begin
                next_d_target = mmd_pkg::MMD_TGT_INT;
            end
            else
            begin
                next_d_target = mmd_pkg::MMD_TGT_EXT;
                next_ext_d_req = 1'b1;
                next_ext_we = d_we;
                next_ext_addr = {7'h00, d_addr};
                next_ext_wdata = d_wdata;
            end
        end
        if (p_req)
        begin
            if (p_in_ram)
            begin
                next_p_target = mmd_pkg::MMD_TGT_INT;
            end
            else if (p_in_rom)
            begin
                // Code that came from outside may not read the protected ROM
                if (ROM_PROTECT && fetch_from_ext)
                begin
                    next_p_rom_denied = 1'b1;
                end
                else
                begin
                    next_p_target = mmd_pkg::MMD_TGT_INT;
                    next_rom_req = 1'b1;
                    next_rom_addr = {program_page_select[0], p_addr};
                    next_p_rom_q = 1'b1;
                end
            end
            else if (!next_ext_d_req)
            begin
                // Data access owns the external bus; a clashing program access is dropped with no target
                next_p_target = mmd_pkg::MMD_TGT_EXT;
                next_ext_p_req = 1'b1;
                next_ext_addr = {program_page_select[6:0], p_addr};
            end
        end
    end

    // Read data return two cycles after the request
    always_comb
    begin
        next_d_rdata = d_rdata;
        next_p_rdata = p_rdata;
        next_hp_rdata = hp_rdata;
        if (d_reg_q)
        begin
            next_d_rdata = reg_rdata_q;
        end
        else if (b_sel_q < 3'(NUM_BLOCKS))
        begin
            next_d_rdata = blk_b_rdata[b_sel_q];
        end
        if (p_rom_q)
        begin
            next_p_rdata = rom_rdata;
        end
        else if (a_sel_q < 3'(NUM_BLOCKS))
        begin
            next_p_rdata = blk_a_rdata[a_sel_q];
        end
        if (hp_rd_q && hp_ok_q && b_sel_q < 3'(NUM_BLOCKS))
        begin
            next_hp_rdata = blk_b_rdata[b_sel_q];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            d_target <= mmd_pkg::MMD_TGT_NONE;
            p_target <= mmd_pkg::MMD_TGT_NONE;
            ext_d_req <= 1'b0;
            ext_p_req <= 1'b0;
            ext_we <= 1'b0;
            ext_addr <= 23'h000000;
            ext_wdata <= 16'h0000;
            rom_req <= 1'b0;
            rom_addr <= 17'h00000;
            p_rom_denied <= 1'b0;
            hp_denied <= 1'b0;
            a_sel_q <= 3'h7;
            b_sel_q <= 3'h7;
            d_reg_q <= 1'b0;
            p_rom_q <= 1'b0;
            hp_rd_q <= 1'b0;
            hp_ok_q <= 1'b0;
            reg_rdata_q <= 16'h0000;
            d_rdata <= 16'h0000;
            p_rdata <= 16'h0000;
            hp_rdata <= 16'h0000;
            pc_load <= 1'b0;
            pc_vector <= `MMD_RESET_VEC;
            page_sel <= `MMD_PAGE_SEL_RESET;
            mode_ctrl <= {`MMD_VPTR_RESET, 1'b1, `MMD_MODE_LOW_RESET};
        end
        else
        begin
            d_target <= next_d_target;
            p_target <= next_p_target;
            ext_d_req <= next_ext_d_req;
            ext_p_req <= next_ext_p_req;
            ext_we <= next_ext_we;
            ext_addr <= next_ext_addr;
            ext_wdata <= next_ext_wdata;
            rom_req <= next_rom_req;
            rom_addr <= next_rom_addr;
            p_rom_denied <= next_p_rom_denied;
            hp_denied <= next_hp_denied;
            a_sel_q <= ram_a_en ? next_a_sel_q : 3'h7;
            b_sel_q <= ram_b_en ? next_b_sel_q : 3'h7;
            d_reg_q <= next_d_reg_q;
            p_rom_q <= next_p_rom_q;
            hp_rd_q <= next_hp_rd_q;
            hp_ok_q <= next_hp_ok_q;
            reg_rdata_q <= next_reg_rdata_q;
            d_rdata <= next_d_rdata;
            p_rdata <= next_p_rdata;
            hp_rdata <= next_hp_rdata;
            pc_load <= vec_valid;
            pc_vector <= vec_addr;
            page_sel <= program_page_select;
            mode_ctrl <= mode_word;
        end
    end
endmodule
`default_nettype wire

//--- mmd_monitor.sv
// Port checker for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module mmd_monitor #(
    parameter bit ROM_PROTECT = 1'b0,
    parameter bit RAM_PROTECT = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requests
    input wire logic d_req,
    input wire logic [15:0] d_addr,
    input wire logic p_req,
    input wire logic [15:0] p_addr,
    input wire logic fetch_from_ext,
    input wire logic hp_req,
    input wire logic hp_we,
    input wire logic [15:0] hp_addr,
    input wire logic vec_take,
    input wire logic [4:0] vec_num,
    // Answers
    input wire logic rom_req,
    input wire logic [16:0] rom_addr,
    input wire logic hp_denied,
    input wire logic p_rom_denied,
    input wire logic [2:0] d_target,
    input wire logic [2:0] p_target,
    input wire logic ext_d_req,
    input wire logic ext_p_req,
    input wire logic [22:0] ext_addr,
    input wire logic pc_load,
    input wire logic [15:0] pc_vector,
    input wire logic [15:0] page_sel,
    input wire logic [15:0] mode_ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic rom_hit;
    // Register copies lag a mode or page write by a cycle, so a fetch right after such a write is judged against the old copies
    assign rom_hit = p_req && !mode_ctrl[6] && p_addr >= 16'h8000 && page_sel[6:1] == 6'h00;
    a_data_ext: assert property (d_req && d_addr >= 16'hA000 |=> ext_d_req && d_target == 3'h4
        && ext_addr == {7'h00, $past(d_addr)}) else $error("data access outside RAM not sent out");
    a_data_ram: assert property (d_req && d_addr >= 16'h0080 && d_addr <= 16'h9FFF
        |=> d_target == 3'h2 && !ext_d_req) else $error("data RAM access not kept inside");
    a_prog_ext: assert property (p_req && !d_req && p_addr >= 16'h8000 && (mode_ctrl[6] || page_sel[6:1] != 6'h00)
        |=> ext_p_req && ext_addr == {page_sel[6:0], $past(p_addr)}) else $error("external program address wrong");
    a_overlay_ram: assert property (p_req && mode_ctrl[5] && p_addr >= 16'h0080 && p_addr <= 16'h7FFF
        |=> p_target == 3'h2 && !ext_p_req) else $error("overlay fetch not served inside");
    a_page_zero: assert property (p_req && !d_req && p_addr <= 16'h007F |=> p_target == 3'h4)
        else $error("data page zero decoded in program space");
    a_rom_fetch: assert property (rom_hit && !(ROM_PROTECT && fetch_from_ext)
        |=> rom_req && rom_addr == {page_sel[0], $past(p_addr)}) else $error("ROM fetch address wrong");
    a_rom_guard: assert property (rom_hit && ROM_PROTECT && fetch_from_ext |=> p_rom_denied && !rom_req)
        else $error("external code reached protected ROM");
    a_host_guard: assert property (hp_req && !hp_we && RAM_PROTECT && (hp_addr < 16'h2000 || hp_addr > 16'h3FFF)
        |=> hp_denied) else $error("host read outside window not refused");
    a_vec_slot: assert property (vec_take |-> ##2 pc_load && pc_vector == {mode_ctrl[15:7], $past(vec_num, 2), 2'b00})
        else $error("vector address wrong");
    a_reset_vec: assert property ($rose(rst_b) |-> ##[1:3] pc_load && pc_vector == 16'hFF80)
        else $error("reset vector missing");
    c_rom: cover property (rom_hit ##1 rom_req);
    c_rom_deny: cover property (p_rom_denied);
    c_host_deny: cover property (hp_denied);
    c_moved_vec: cover property (pc_load && pc_vector != 16'hFF80);
endmodule
bind mmd_decoder mmd_monitor #(.ROM_PROTECT(ROM_PROTECT), .RAM_PROTECT(RAM_PROTECT)) u_mon (.clk(clk), .rst_b(rst_b),
    .d_req(d_req), .d_addr(d_addr), .p_req(p_req), .p_addr(p_addr), .fetch_from_ext(fetch_from_ext),
    .hp_req(hp_req), .hp_we(hp_we), .hp_addr(hp_addr), .vec_take(vec_take), .vec_num(vec_num), .rom_req(rom_req),
    .rom_addr(rom_addr), .hp_denied(hp_denied), .p_rom_denied(p_rom_denied), .d_target(d_target),
    .p_target(p_target), .ext_d_req(ext_d_req), .ext_p_req(ext_p_req), .ext_addr(ext_addr), .pc_load(pc_load),
    .pc_vector(pc_vector), .page_sel(page_sel), .mode_ctrl(mode_ctrl));
`default_nettype wire

//--- mmd_pkg.sv
// Types shared by the memory map decoder files
package mmd_pkg;
    typedef enum logic [2:0]
    {
        MMD_TGT_NONE = 3'h1,
        MMD_TGT_INT = 3'h2,
        MMD_TGT_EXT = 3'h4
    } mmd_target_t;
endpackage

//--- mmd_ram_block.sv
// One dual-access RAM block: two ports, each may read, port b may write
`timescale 1ns/1ps
`default_nettype none
module mmd_ram_block #(
    parameter int AW = 13,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk,
    // Port a, read only
    input wire logic a_en,
    input wire logic [AW-1:0] a_addr,
    output logic [DW-1:0] a_rdata,
    // Port b, read or write
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] next_a_rdata;
    logic [DW-1:0] next_b_rdata;

    always_comb
    begin
        next_a_rdata = a_en ? mem[a_addr] : a_rdata;
        next_b_rdata = (b_en && !b_we) ? mem[b_addr] : b_rdata;
    end

    // Two accesses in one cycle per block
    always_ff @(posedge clk)
    begin
        a_rdata <= next_a_rdata;
        b_rdata <= next_b_rdata;
        if (b_en && b_we)
        begin
            mem[b_addr] <= b_wdata;
        end
    end
endmodule
`default_nettype wire

//--- mmd_regs.svh
// Register offsets, field positions, reset values and map bounds for the memory map decoder
`ifndef MMD_REGS_SVH
`define MMD_REGS_SVH
`define MMD_PAGE_SEL_ADDR 16'h001E
`define MMD_MODE_CTRL_ADDR 16'h001D
`define MMD_PAGE_SEL_RESET 16'h0000
`define MMD_VPTR_RESET 9'h1FF
`define MMD_MODE_LOW_RESET 6'h00
`define MMD_VPTR_MSB 15
`define MMD_VPTR_LSB 7
`define MMD_ROM_EN_BIT 6
`define MMD_RAM_OVERLAY_BIT 5
`define MMD_ADDRESS_VISIBILITY_BIT 4
`define MMD_ROM_IN_DATA_SPACE_BIT 3
`define MMD_CLOCK_OUTPUT_DISABLE_BIT 2
`define MMD_RAM_LO 16'h0080
`define MMD_RAM_HI 16'h9FFF
`define MMD_OVL_HI 16'h7FFF
`define MMD_RESET_VEC 16'hFF80
`define MMD_HP_RD_LO 16'h2000
`define MMD_HP_RD_HI 16'h3FFF
`define MMD_ROM_LO 16'h8000
`define MMD_VEC_WORDS 4
`endif

//--- mmd_rom_model.sv
// Behavioural ROM array answering the decoder
`timescale 1ns/1ps
`default_nettype none
module mmd_rom_model (
    // Clock
    input wire logic clk,
    // ROM port
    input wire logic rom_req,
    input wire logic [16:0] rom_addr,
    output logic [15:0] rom_rdata
);
    logic [15:0] rom_word;
    assign rom_word = rom_addr[15:0] ^ {rom_addr[16], 15'h2A5C};
    // Word stands while rom_req is high, when the decoder takes it; otherwise the inverse shows so stale data is caught
    assign rom_rdata = rom_req ? rom_word : ~rom_word;
endmodule
`default_nettype wire

//--- mmd_vector_gen.sv
// Vector address generator: pointer page plus four words per vector slot
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.svh"
module mmd_vector_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Vector request
    input wire logic take,
    input wire logic is_hw_reset,
    input wire logic [4:0] vec_num,
    input wire logic [8:0] vptr,
    // Result
    output logic vec_valid,
    output logic [15:0] vec_addr
);
    logic next_vec_valid;
    logic [15:0] next_vec_addr;

    always_comb
    begin
        next_vec_valid = take;
        next_vec_addr = vec_addr;
        if (take)
        begin
            if (is_hw_reset)
            begin
                next_vec_addr = `MMD_RESET_VEC;
            end
            else
            begin
                next_vec_addr = {vptr, vec_num, 2'b00};
            end
        end
    end

    // Program counter load with vector address
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            vec_valid <= 1'b0;
            vec_addr <= `MMD_RESET_VEC;
        end
        else
        begin
            vec_valid <= next_vec_valid;
            vec_addr <= next_vec_addr;
        end
    end
endmodule
`default_nettype wire

//--- tb_memory_map_decoder.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_decoder;
    logic clk = 1'b0, rst_b = 1'b0, pin = 1'b0, d_req = 1'b0, d_we = 1'b0, p_req = 1'b0, fext = 1'b0;
    logic hp_req = 1'b0, hp_we = 1'b0, vec_take = 1'b0;
    logic [15:0] d_addr = 16'h0000, d_wdata = 16'h0000, p_addr = 16'h0000, hp_addr = 16'h0000, hp_wdata = 16'h0000;
    logic [4:0] vec_num = 5'h00;
    logic rom_req, hp_denied, p_rom_denied, ext_d_req, ext_p_req, ext_we, pc_load;
    logic [16:0] rom_addr;
    logic [15:0] rom_rdata, d_rdata, p_rdata, hp_rdata, ext_wdata, pc_vector, page_sel, mode_ctrl, v;
    logic [2:0] d_target, p_target;
    logic [22:0] ext_addr;
    logic [15:0] tbl [11] = '{16'h0080, 16'h1FFF, 16'h2000, 16'h4000, 16'h6000, 16'h8000, 16'h9FFF, 16'h007F,
        16'hA000, 16'hFFFF, 16'h001E};
    int fail_count = 0, n_checks = 0, cyc = 0, i, k, mem[int], page = 0, mode = 16'hFF80;
    mmd_decoder #(.ROM_PROTECT(1'b1), .RAM_PROTECT(1'b1)) DUT (.clk(clk), .rst_b(rst_b),
        .rom_enable_select_pin(pin), .d_req(d_req), .d_we(d_we), .d_addr(d_addr), .d_wdata(d_wdata),
        .p_req(p_req), .p_addr(p_addr), .fetch_from_ext(fext), .hp_req(hp_req), .hp_we(hp_we), .hp_addr(hp_addr),
        .hp_wdata(hp_wdata), .vec_take(vec_take), .vec_num(vec_num), .rom_req(rom_req), .rom_addr(rom_addr),
        .rom_rdata(rom_rdata), .d_rdata(d_rdata), .p_rdata(p_rdata), .hp_rdata(hp_rdata), .hp_denied(hp_denied),
        .p_rom_denied(p_rom_denied), .d_target(d_target), .p_target(p_target), .ext_d_req(ext_d_req),
        .ext_p_req(ext_p_req), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .pc_load(pc_load),
        .pc_vector(pc_vector), .page_sel(page_sel), .mode_ctrl(mode_ctrl));
    mmd_rom_model u_rom (.clk(clk), .rom_req(rom_req), .rom_addr(rom_addr), .rom_rdata(rom_rdata));
    always #50 clk = ~clk;
    // Whole run needs well under 2000 cycles; this ceiling only cuts a hang
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [2:0] dtgt(input logic [15:0] a);
        return (a >= 16'h0080 && a <= 16'h9FFF) || a == 16'h001E || a == 16'h001D ? 3'h2 : 3'h4;
    endfunction
    task automatic dacc(input logic we, input logic [15:0] a, input logic [15:0] w);
        d_req = 1'b1;
        d_we = we;
        d_addr = a;
        d_wdata = w;
        step(1);
        d_req = 1'b0;
        d_we = 1'b0;
        chk("d_target", dtgt(a), d_target);
        if (dtgt(a) == 3'h4)
            chk("ext_addr", {7'h00, a}, ext_addr);
        if (dtgt(a) == 3'h4)
            chk("ext_we_wdata", {6'h00, we, w}, {6'h00, ext_we, ext_wdata});
        step(1);
        if (!we && dtgt(a) == 3'h2)
            chk("d_rdata", a == 16'h001E ? page : a == 16'h001D ? mode : mem[a], d_rdata);
        else if (we && a == 16'h001E)
            page = w & 16'h007F;
        else if (we && a == 16'h001D)
            mode = w;
        else if (we)
            mem[a] = w;
    endtask
    task automatic pacc(input logic [15:0] a, input logic fx);
        logic rom;
        logic ram;
        rom = !mode[6] && a >= 16'h8000 && page < 2;
        ram = mode[5] && a >= 16'h0080 && a < 16'h8000;
        p_req = 1'b1;
        p_addr = a;
        fext = fx;
        step(1);
        p_req = 1'b0;
        fext = 1'b0;
        if (rom && fx)
            chk("p_rom_denied", 1'b1, p_rom_denied);
        else if (rom)
            chk("rom_addr", {page[0], a}, rom_addr);
        else if (ram)
            chk("p_target", 3'h2, p_target);
        else
            chk("ext_addr", {page[6:0], a}, ext_addr);
        step(2);
        if (rom && !fx)
            chk("p_rdata", a ^ {page[0], 15'h2A5C}, p_rdata);
        else if (ram)
            chk("p_rdata", mem[a], p_rdata);
    endtask
    task automatic hacc(input logic we, input logic [15:0] a, input logic [15:0] w);
        hp_req = 1'b1;
        hp_we = we;
        hp_addr = a;
        hp_wdata = w;
        step(1);
        hp_req = 1'b0;
        hp_we = 1'b0;
        if (!we && (a < 16'h2000 || a > 16'h3FFF))
            chk("hp_denied", 1'b1, hp_denied);
        step(2);
        if (we)
            mem[a] = w;
        else if (a >= 16'h2000 && a <= 16'h3FFF)
            chk("hp_rdata", mem[a], hp_rdata);
    endtask
    task automatic wait_vec(input logic [15:0] e);
        for (i = 0; i < 6 && pc_load !== 1'b1; i++)
            step(1);
        chk("pc_load", 1'b1, pc_load);
        chk("pc_vector", e, pc_vector);
    endtask
    task automatic do_reset(input logic p);
        rst_b = 1'b0;
        pin = p;
        step(3);
        rst_b = 1'b1;
        wait_vec(16'hFF80);
        page = 0;
        mode = {9'h1FF, p, 6'h00};
        pin = ~p;
        step(2);
        chk("page_sel", 16'h0000, page_sel);
        chk("mode_ctrl", mode, mode_ctrl);
    endtask
    initial
    begin
        v = $urandom(55712);
        do_reset(1'b0);
        $display("Test reset done");
        for (k = 0; k < 11; k++)
        begin
            dacc(1'b1, tbl[k], $urandom);
            dacc(1'b0, tbl[k], 16'h0000);
        end
        chk("page_sel", page, page_sel);
        $display("Test data map done");
        dacc(1'b1, 16'h001D, mode | 16'h0020);
        dacc(1'b0, 16'h001D, 16'h0000);
        dacc(1'b1, 16'h001E, 16'h0000);
        pacc(16'h0080, 1'b0);
        pacc(16'h0050, 1'b0);
        pacc(16'h9000, 1'b0);
        pacc(16'h8000, 1'b1);
        dacc(1'b1, 16'h001E, 16'h0001);
        pacc(16'hFF80, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            dacc(1'b1, 16'h001E, $urandom);
            pacc(16'h1FFF, 1'b0);
            pacc(16'h8000 | 16'($urandom), 1'b0);
        end
        dacc(1'b1, 16'h001D, mode & 16'hFFDF);
        pacc(16'h0080, 1'b0);
        $display("Test program map done");
        hacc(1'b1, 16'h2100, $urandom);
        dacc(1'b0, 16'h2100, 16'h0000);
        hacc(1'b0, 16'h2100, 16'h0000);
        hacc(1'b1, 16'h0200, $urandom);
        dacc(1'b0, 16'h0200, 16'h0000);
        hacc(1'b0, 16'h0200, 16'h0000);
        hacc(1'b0, 16'h4000, 16'h0000);
        $display("Test host port done");
        dacc(1'b1, 16'h001D, {v[15:7], mode[6:0]});
        for (k = 0; k < 6; k++)
        begin
            vec_num = 5'($urandom);
            vec_take = 1'b1;
            step(1);
            vec_take = 1'b0;
            wait_vec({mode[15:7], vec_num, 2'b00});
        end
        $display("Test vectors done");
        do_reset(1'b1);
        pacc(16'h9000, 1'b0);
        dacc(1'b1, 16'h001D, 16'hFF80);
        pacc(16'h9000, 1'b0);
        $display("Test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
